// File: hpbr_pkg.sv
// Package with constants for the burst read host controller
package hpbr_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int LEN_W = 8;
    // Address setup before the latch strobe falls, in ns
    localparam int ADDR_SETUP_NS = 100;
    localparam int CLK_PERIOD_NS = 100;
    localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Ready wait limit in cycles before the read is abandoned
    localparam int READY_TIMEOUT_CYC = 255;
    // Idle levels of the port pins
    localparam logic CS_IDLE_N = 1'b1;
    localparam logic STROBE_IDLE_N = 1'b1;
    localparam logic ALS_IDLE = 1'b0;
    localparam logic BUS_STYLE_LATCHED = 1'b0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
endpackage : hpbr_pkg

// File: hpbr_host.sv
// Host controller that runs read bursts on a latched-address parallel port
//
// Behaviour
// - Every cycle of a burst here is a read; no write is mixed in.
// - A burst covers one contiguous address range given by start and length.
// - The burst starts at its lowest address and the device steps upward.
// - The address is driven only for the first access and then left unchanged.
// - The host drives the start address and pulls chip select low together.
// - The latch strobe goes high, then low after address setup, to latch.
// - The latch strobe stays low for the rest of the burst.
// - A read is marked by pulling the read strobe low; the device drives data.
// - The host waits for ready high, or for the wait limit, before raising the read strobe.
// - Later reads lower the read strobe only; the device increments its address.
`timescale 1ns/1ns
module hpbr_host #(
    parameter int ADDR_SETUP = hpbr_pkg::ADDR_SETUP_CYC,
    parameter int READY_TIMEOUT = hpbr_pkg::READY_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    // User request
    input wire logic i_START,
    input wire logic [hpbr_pkg::ADDR_W-1:0] i_START_ADDR,
    input wire logic [hpbr_pkg::LEN_W-1:0] i_LENGTH,
    output logic o_BUSY,
    output logic o_DATA_VALID,
    output logic [hpbr_pkg::DATA_W-1:0] o_DATA,
    output logic o_DONE,
    output logic o_TIMEOUT,
    // Device port
    output logic [hpbr_pkg::ADDR_W-1:0] o_ADDR,
    output logic o_CHIP_SELECT_N,
    output logic o_ADDRESS_LATCH_STROBE,
    output logic o_READ_STROBE_N,
    output logic o_WRITE_STROBE_N,
    output logic o_BUS_STYLE_SELECT,
    input wire logic [hpbr_pkg::DATA_W-1:0] i_DATA,
    output logic [hpbr_pkg::DATA_W-1:0] o_DATA_OUT,
    output logic o_DATA_OE_N,
    input wire logic i_READY_ACK
);
    typedef enum logic [6:0] {
        ST_IDLE   = 7'b0000001,
        ST_LATCH  = 7'b0000010,
        ST_SETUP  = 7'b0000100,
        ST_STROBE = 7'b0001000,
        ST_WAITLO = 7'b0010000,
        ST_WAITHI = 7'b0100000,
        ST_END    = 7'b1000000
    } hpbr_state_t;

    hpbr_state_t state;
    logic [hpbr_pkg::LEN_W-1:0] remaining;
    logic [8:0] timer;
    logic take_start;
    logic wait_phase;
    logic ready_seen;
    logic wait_expired;
    logic last_byte;
    logic setup_over;

    // Step a wait count by one
    function automatic logic [8:0] step_count(input logic [8:0] value);
        return value + 9'h001;
    endfunction : step_count

    // Start taken only in idle and only for a non-empty burst
    assign take_start = (state == ST_IDLE) && i_START && (i_LENGTH != '0);
    // Cycles in which ready is sampled
    assign wait_phase = (state == ST_WAITLO) || (state == ST_WAITHI);
    // Ready counts once seen low first, or on the second sample
    assign ready_seen = wait_phase && i_READY_ACK && (state == ST_WAITHI || timer != '0);
    // Wait limit reached with no usable ready
    assign wait_expired = wait_phase && !ready_seen && (timer >= 9'(READY_TIMEOUT));
    // No more reads owed, or the burst was cut short
    assign last_byte = (remaining == '0) || o_TIMEOUT;
    // Address has had its setup time under the raised latch strobe
    assign setup_over = (state == ST_LATCH) && (step_count(timer) >= 9'(ADDR_SETUP));

    // Sequencer state
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (take_start) begin
                        state <= ST_LATCH;
                    end
                end
                ST_LATCH: begin
                    if (setup_over) begin
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    state <= ST_STROBE;
                end
                ST_STROBE: begin
                    // One cycle for the device to pull ready low
                    state <= ST_WAITLO;
                end
                ST_WAITLO, ST_WAITHI: begin
                    if (ready_seen || wait_expired) begin
                        state <= ST_END;
                    end else if (!i_READY_ACK) begin
                        state <= ST_WAITHI;
                    end
                end
                ST_END: begin
                    if (last_byte) begin
                        state <= ST_IDLE;
                    end else begin
                        state <= ST_STROBE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Wait counter for address setup and for ready
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            timer <= '0;
        end else if (state == ST_LATCH || wait_phase) begin
            timer <= step_count(timer);
        end else begin
            timer <= '0;
        end
    end

    // Reads still owed in this burst
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            remaining <= '0;
        end else if (take_start) begin
            remaining <= i_LENGTH;
        end else if (ready_seen) begin
            remaining <= remaining - 8'h01;
        end else if (wait_expired) begin
            // Leaves one; o_TIMEOUT makes last_byte true, so the burst closes without another read
            remaining <= 8'h01;
        end
    end

    // Address pins and chip select
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            o_ADDR <= '0;
            o_CHIP_SELECT_N <= hpbr_pkg::CS_IDLE_N;
        end else if (take_start) begin
            o_ADDR <= i_START_ADDR;
            o_CHIP_SELECT_N <= 1'b0;
        end else if (state == ST_END && last_byte) begin
            o_CHIP_SELECT_N <= hpbr_pkg::CS_IDLE_N;
        end
    end

    // Latch strobe: pass, latch, hold low, rise to close
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            o_ADDRESS_LATCH_STROBE <= hpbr_pkg::ALS_IDLE;
        end else if (take_start) begin
            o_ADDRESS_LATCH_STROBE <= 1'b1;
        end else if (setup_over) begin
            o_ADDRESS_LATCH_STROBE <= 1'b0;
        end else if (state == ST_END && last_byte) begin
            o_ADDRESS_LATCH_STROBE <= 1'b1;
        end else if (state == ST_IDLE && !i_START) begin
            // Back to its idle level one cycle after the close
            o_ADDRESS_LATCH_STROBE <= hpbr_pkg::ALS_IDLE;
        end
    end

    // Read strobe, released only on ready or on the wait limit
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            o_READ_STROBE_N <= hpbr_pkg::STROBE_IDLE_N;
        end else if (state == ST_SETUP) begin
            o_READ_STROBE_N <= 1'b0;
        end else if (ready_seen || wait_expired) begin
            o_READ_STROBE_N <= hpbr_pkg::STROBE_IDLE_N;
        end else if (state == ST_END && !last_byte) begin
            // Address pins untouched; device increments itself
            o_READ_STROBE_N <= 1'b0;
        end
    end

    // Captured byte and its one-cycle marker
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            o_DATA_VALID <= 1'b0;
            o_DATA <= hpbr_pkg::ZERO_BYTE;
        end else begin
            o_DATA_VALID <= ready_seen;
            if (ready_seen) begin
                o_DATA <= i_DATA;
            end
        end
    end

    // Busy, done and timeout status
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            o_BUSY <= 1'b0;
            o_DONE <= 1'b0;
            o_TIMEOUT <= 1'b0;
        end else begin
            o_DONE <= (state == ST_END) && last_byte;
            if (take_start) begin
                o_BUSY <= 1'b1;
            end else if (state == ST_END && last_byte) begin
                o_BUSY <= 1'b0;
            end
            // Set and idle clear never meet in one cycle
            if (wait_expired) begin
                o_TIMEOUT <= 1'b1;
            end else if (state == ST_IDLE) begin
                o_TIMEOUT <= 1'b0;
            end
        end
    end

    // Fixed pins: write strobe idle, data bus never driven, latched style
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            o_WRITE_STROBE_N <= hpbr_pkg::STROBE_IDLE_N;
            o_DATA_OE_N <= 1'b1;
            o_DATA_OUT <= hpbr_pkg::ZERO_BYTE;
            o_BUS_STYLE_SELECT <= hpbr_pkg::BUS_STYLE_LATCHED;
        end else begin
            o_WRITE_STROBE_N <= hpbr_pkg::STROBE_IDLE_N;
            o_DATA_OE_N <= 1'b1;
            o_DATA_OUT <= hpbr_pkg::ZERO_BYTE;
            o_BUS_STYLE_SELECT <= hpbr_pkg::BUS_STYLE_LATCHED;
        end
    end
endmodule : hpbr_host

// File: hpbr_monitor.sv
// Assertions on the burst read host ports
`timescale 1ns/1ns
module hpbr_monitor #(parameter int ADDR_SETUP = 1) (
    // Watched ports
    input wire logic I_CORE_CLK, input wire logic I_RESET, input wire logic o_BUSY,
    input wire logic o_DATA_VALID, input wire logic [7:0] o_DATA, input wire logic o_DONE,
    input wire logic [11:0] o_ADDR, input wire logic o_CHIP_SELECT_N, input wire logic i_READY_ACK,
    input wire logic o_ADDRESS_LATCH_STROBE, input wire logic o_READ_STROBE_N,
    input wire logic o_WRITE_STROBE_N, input wire logic o_BUS_STYLE_SELECT,
    input wire logic [7:0] i_DATA, input wire logic o_DATA_OE_N
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);
    // Opening steps of a burst
    sequence s_open;
        !o_CHIP_SELECT_N && o_ADDRESS_LATCH_STROBE ##ADDR_SETUP !o_ADDRESS_LATCH_STROBE
            ##1 !o_READ_STROBE_N;
    endsequence
    a_idle_pins: assert property (o_WRITE_STROBE_N && o_DATA_OE_N)
        else $error("host drove data");
    a_style_low: assert property (!o_BUS_STYLE_SELECT) else $error("style");
    a_addr_fixed: assert property (o_BUSY && $past(o_BUSY) |-> $stable(o_ADDR))
        else $error("addr moved");
    a_read_latch: assert property (!o_READ_STROBE_N |-> !o_ADDRESS_LATCH_STROBE && !o_CHIP_SELECT_N)
        else $error("strobes");
    a_open_burst: assert property ($rose(o_BUSY) |-> s_open) else $error("open");
    a_read_wait: assert property ($rose(o_READ_STROBE_N) |-> $past(i_READY_ACK))
        else $error("early release");
    a_byte_taken: assert property (o_DATA_VALID |-> o_DATA == $past(i_DATA))
        else $error("byte");
    a_close_burst: assert property (o_DONE |-> o_ADDRESS_LATCH_STROBE ##1 !o_ADDRESS_LATCH_STROBE)
        else $error("close");
endmodule : hpbr_monitor
bind hpbr_host hpbr_monitor #(.ADDR_SETUP(ADDR_SETUP)) i_hpbr_monitor (.*);

// File: hpbr_dev_model.sv
// Behavioural device port answering read bursts
`timescale 1ns/1ns
module hpbr_dev_model (
    // Port pins and answer delay
    input wire logic clk, input wire logic cs_n, input wire logic als, input wire logic rd_n,
    input wire logic [11:0] addr, input wire logic [2:0] lat,
    output logic [7:0] data = 8'hFF, output logic rdy = 1'b1
);
    logic [11:0] ptr = 12'h000;
    logic first = 1'b1;
    // Latch on falling strobe, rising strobe ends burst
    always @(negedge als) if (!cs_n) ptr = addr;
    always @(posedge als) first = 1'b1;
    // Step address after the first read, dip ready, then present data
    always @(negedge rd_n) if (!cs_n) begin
        ptr = first ? ptr : ptr + 12'h001;
        first = 1'b0;
        rdy = 1'b0;
        repeat (lat) @(posedge clk);
        #7 data = ptr[7:0] ^ ptr[11:4];
        rdy = 1'b1;
    end
    // Released bus stops showing the last byte
    always @(posedge rd_n) data = ~data;
endmodule : hpbr_dev_model

// File: hpbr_tb.sv
// Self-checking bench for the burst read host
`timescale 1ns/1ns
module tb;
    logic I_CORE_CLK = 1'b0, I_RESET = 1'b1, i_START = 1'b0, i_READY_ACK, o_BUSY, o_DATA_VALID;
    logic o_DONE, o_TIMEOUT, o_CHIP_SELECT_N, o_ADDRESS_LATCH_STROBE, o_READ_STROBE_N;
    logic o_WRITE_STROBE_N, o_BUS_STYLE_SELECT, o_DATA_OE_N;
    logic [11:0] i_START_ADDR = 12'h000, o_ADDR;
    logic [7:0] i_LENGTH = 8'h01, o_DATA, i_DATA, o_DATA_OUT, q[$];
    logic [2:0] lat = 3'h0;
    int fails = 0, n_compared = 0;
    // Clock and the two parties
    always #50 I_CORE_CLK = ~I_CORE_CLK;
    hpbr_host #(.READY_TIMEOUT(8)) i_hpbr_host (.*);
    hpbr_dev_model i_hpbr_dev_model (.clk(I_CORE_CLK), .cs_n(o_CHIP_SELECT_N),
        .als(o_ADDRESS_LATCH_STROBE), .rd_n(o_READ_STROBE_N), .addr(o_ADDR), .lat(lat),
        .data(i_DATA), .rdy(i_READY_ACK));
    task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] s);
        n_compared++;
        if (s !== e) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask : cmp8
    task automatic print_verdict();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    // Oldest note against each delivered byte; at done, no notes left, timeout low, data out zero
    always @(negedge I_CORE_CLK) begin
        if (o_DATA_VALID === 1'b1) cmp8("byte", q.pop_front(), o_DATA);
        if (o_DONE === 1'b1) cmp8("left", 8'h00, 8'(q.size()));
        if (o_DONE === 1'b1) cmp8("timeout", 8'h00, {7'h00, o_TIMEOUT});
        if (o_DONE === 1'b1) cmp8("data out", 8'h00, o_DATA_OUT);
    end
    task automatic burst(input logic [11:0] a, input logic [7:0] n);
        int k;
        @(negedge I_CORE_CLK);
        {i_START, i_START_ADDR, i_LENGTH, lat} = {1'b1, a, n, 3'($urandom % 6)};
        for (k = 0; k < n; k++) q.push_back(8'(a + k) ^ 8'((a + k) >> 4));
        @(negedge I_CORE_CLK);
        i_START = 1'b0;
        for (k = 0; k < 3000 && o_DONE !== 1'b1; k++) @(negedge I_CORE_CLK);
        if (k == 3000) begin fails++; print_verdict(); end
    endtask : burst
    // Reset, refused start, then bursts
    initial begin
        void'($urandom(32'hA71D));
        repeat (6) @(negedge I_CORE_CLK);
        {I_RESET, i_START, i_LENGTH} = {1'b0, 1'b1, 8'h00};
        repeat (2) @(negedge I_CORE_CLK);
        cmp8("busy", 8'h00, {7'h00, o_BUSY});
        burst(12'hFFE, 8'h04);
        burst(12'h000, 8'hFF);
        repeat (12) burst(12'($urandom), 8'($urandom % 8 + 1));
        print_verdict();
    end
endmodule : tb
